// [tccc_consts.vh]
`ifndef TCCC_CONSTS_VH
`define TCCC_CONSTS_VH
// Register indexes, not byte offsets (byte address is index * 4)
`define TCCC_IDX_CH0_LOW 8'h00da
`define TCCC_IDX_CH0_HIGH 8'h00db
`define TCCC_IDX_CH1_LOW 8'h00dc
`define TCCC_IDX_CH1_HIGH 8'h00dd
`define TCCC_IDX_CH2_LOW 8'h00de
`define TCCC_IDX_CH2_HIGH 8'h00df
`define TCCC_IDX_CH0_CTL 8'h00e5
`define TCCC_IDX_CH1_CTL 8'h00e6
`define TCCC_IDX_CH2_CTL 8'h00e7
`define TCCC_IDX_FLAGS 8'h00e4
`define TCCC_IDX_IRQ_STATUS 8'h00f0
`define TCCC_IDX_IRQ_MASK 8'h00f1
// Control register fields
`define TCCC_CTL_RESET 8'h0040
`define TCCC_CTL_IM 6
`define TCCC_CTL_ACT_HI 5
`define TCCC_CTL_ACT_LO 3
`define TCCC_CTL_SEL 2
`define TCCC_CTL_EDGE_HI 1
`define TCCC_CTL_EDGE_LO 0
// Compare actions
`define TCCC_ACT_SET 3'h0
`define TCCC_ACT_CLR 3'h1
`define TCCC_ACT_TGL 3'h2
`define TCCC_ACT_SET_UP 3'h3
`define TCCC_ACT_CLR_UP 3'h4
`define TCCC_ACT_CLR0_SET 3'h5
`define TCCC_ACT_SET0_CLR 3'h6
// Capture edges
`define TCCC_EDGE_RISE 2'h1
`define TCCC_EDGE_FALL 2'h2
`define TCCC_EDGE_BOTH 2'h3
// Timer modes
`define TCCC_MODE_UPDOWN 2'h3
`define TCCC_CNT_ZERO 16'h0000
// Flag register bit positions
`define TCCC_FLAG_CH0 5
`define TCCC_BYTE_ZERO 8'h00
`endif

// [tccc_edge_det.v]
`timescale 1ns/100ps
`include "tccc_consts.vh"
module tccc_edge_det (
  input wire clk,
  input wire rst,
  input wire pin_in,
  input wire [1:0] edge_sel,
  output wire hit
);
  reg prev_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= pin_in;
    end
  end
  wire rise = pin_in & ~prev_q;
  wire fall = ~pin_in & prev_q;
  assign hit = (edge_sel == `TCCC_EDGE_RISE) ? rise :
               (edge_sel == `TCCC_EDGE_FALL) ? fall :
               (edge_sel == `TCCC_EDGE_BOTH) ? (rise | fall) : 1'b0;
endmodule

// [tccc_out_ctl.v]
`timescale 1ns/100ps
`include "tccc_consts.vh"
module tccc_out_ctl (
  input wire clk,
  input wire rst,
  input wire enable,
  input wire [2:0] action,
  input wire dual_ok,
  input wire match_own,
  input wire match_ch0,
  input wire count_down,
  input wire updown_mode,
  input wire at_zero,
  output reg out_q
);
  reg out_d;
  always @* begin
    out_d = out_q;
    if (enable) begin
      case (action)
        `TCCC_ACT_SET: if (match_own) out_d = 1'b1;
        `TCCC_ACT_CLR: if (match_own) out_d = 1'b0;
        `TCCC_ACT_TGL: if (match_own) out_d = ~out_q;
        // set up, clear at zero or down
        `TCCC_ACT_SET_UP: begin
          if (match_own & ~count_down) out_d = 1'b1;
          else if (updown_mode & match_own & count_down) out_d = 1'b0;
          else if (~updown_mode & at_zero) out_d = 1'b0;
        end
        // clear up, set at zero or down
        `TCCC_ACT_CLR_UP: begin
          if (match_own & ~count_down) out_d = 1'b0;
          else if (updown_mode & match_own & count_down) out_d = 1'b1;
          else if (~updown_mode & at_zero) out_d = 1'b1;
        end
        // low at ch0 value, high at own
        `TCCC_ACT_CLR0_SET: if (dual_ok) begin
          if (match_own) out_d = 1'b1;
          else if (match_ch0) out_d = 1'b0;
        end
        // high at ch0 value, low at own
        `TCCC_ACT_SET0_CLR: if (dual_ok) begin
          if (match_own) out_d = 1'b0;
          else if (match_ch0) out_d = 1'b1;
        end
        default: out_d = out_q;
      endcase
    end
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      out_q <= 1'b0;
    end else begin
      out_q <= out_d;
    end
  end
endmodule

// [tccc_channels.v]
// What this block does
// - Control bit 6 is the channel interrupt mask, reset to one.
// - Bits 5:3 select compare output action, reset zero.
// - Codes 000 set, 001 clear, 010 toggle output on match.
// - Code 011 sets on up-match, clears at zero or on down-match.
// - Code 100 clears on up-match, sets at zero or on down-match.
// - Channel 1 code 101: low at channel 0 value, high at own.
// - Channel 1 code 110: high at channel 0 value, low at own.
// - Channel 2 supports the same dual-value codes with its own value.
// - Bit 2 selects capture (0) or compare (1), reset zero.
// - Bits 1:0 pick capture edge: none, rising, falling, both.
// - Each channel keeps a 16-bit value as two bytes, reset zero.
// - Channel 2 control mirrors channel 0 fields on its own value.
// - Channel flags set on events; writing 0 clears, 1 ignored.
// - Up/down timer mode supplies the compare-down events.
// - Each channel pulses its own DMA trigger on compare.
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/100ps
`include "tccc_consts.vh"
module tccc_channels #(
  parameter NCH = 3
) (
  input wire clk,
  input wire rst,
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire [15:0] timer_count,
  input wire count_down,
  input wire [1:0] timer_mode,
  input wire [2:0] capture_pin,
  output wire [2:0] compare_out,
  output reg ch0_dma_trigger,
  output reg ch1_dma_trigger,
  output reg ch2_dma_trigger,
  output wire irq
);
  // Byte address from register index
  function [9:0] tccc_addr;
    input integer idx;
    begin
      tccc_addr = {idx[7:0], 2'b00};
    end
  endfunction

  reg [7:0] ctl_q [0:NCH-1];
  reg [15:0] val_q [0:NCH-1];
  reg [NCH-1:0] flag_q;
  reg [NCH-1:0] ist_q;
  reg [NCH-1:0] imask_q;
  reg rsp_q;
  wire [NCH-1:0] cap_hit;
  wire [NCH-1:0] cmp_hit;
  wire [NCH-1:0] evt;
  wire updown = (timer_mode == `TCCC_MODE_UPDOWN);
  wire at_zero = (timer_count == `TCCC_CNT_ZERO);
  wire acc = avs_read | avs_write;

  // One wait state: request seen, answer on the next edge
  assign avs_waitrequest = acc & ~rsp_q;
  wire wr_go = avs_write & rsp_q;
  wire rd_go = avs_read & rsp_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_q <= 1'b0;
    end else begin
      rsp_q <= acc & ~rsp_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gch
      wire sel_cmp = ctl_q[g][`TCCC_CTL_SEL];
      wire own_eq = (timer_count == val_q[g]);
      tccc_edge_det u_edge (
        .clk(clk),
        .rst(rst),
        .pin_in(capture_pin[g]),
        .edge_sel(ctl_q[g][`TCCC_CTL_EDGE_HI:`TCCC_CTL_EDGE_LO]),
        .hit(cap_hit[g])
      );
      assign cmp_hit[g] = sel_cmp & own_eq;
      assign evt[g] = cmp_hit[g] | (~sel_cmp & cap_hit[g]);
      // dual-value codes only on channels 1 and 2
      tccc_out_ctl u_out (
        .clk(clk),
        .rst(rst),
        .enable(sel_cmp),
        .action(ctl_q[g][`TCCC_CTL_ACT_HI:`TCCC_CTL_ACT_LO]),
        .dual_ok(g != 0),
        .match_own(own_eq),
        .match_ch0(timer_count == val_q[0]),
        .count_down(count_down),
        .updown_mode(updown),
        .at_zero(at_zero),
        .out_q(compare_out[g])
      );
      wire [9:0] a_lo = tccc_addr(`TCCC_IDX_CH0_LOW + 2 * g);
      wire [9:0] a_hi = tccc_addr(`TCCC_IDX_CH0_HIGH + 2 * g);
      wire [9:0] a_ct = tccc_addr(`TCCC_IDX_CH0_CTL + g);
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          ctl_q[g] <= `TCCC_CTL_RESET;
          val_q[g] <= {`TCCC_BYTE_ZERO, `TCCC_BYTE_ZERO};
        end else begin
          // stored as written, bit 7 included
          if (wr_go && avs_address == a_ct) ctl_q[g] <= avs_writedata[7:0];
          if (~sel_cmp & cap_hit[g]) begin
            val_q[g] <= timer_count;
          end else begin
            if (wr_go && avs_address == a_lo) val_q[g][7:0] <= avs_writedata[7:0];
            if (wr_go && avs_address == a_hi) val_q[g][15:8] <= avs_writedata[7:0];
          end
        end
      end
    end
  endgenerate

  // one-cycle DMA trigger per channel compare
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ch0_dma_trigger <= 1'b0;
      ch1_dma_trigger <= 1'b0;
      ch2_dma_trigger <= 1'b0;
    end else begin
      ch0_dma_trigger <= cmp_hit[0];
      ch1_dma_trigger <= cmp_hit[1];
      ch2_dma_trigger <= cmp_hit[2];
    end
  end

  // Mask bit gates whether an event counts as the channel's interrupt condition
  wire [NCH-1:0] irq_evt;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gev
      assign irq_evt[g] = evt[g] & ctl_q[g][`TCCC_CTL_IM];
    end
  endgenerate

  wire wr_flags = wr_go && avs_address == tccc_addr(`TCCC_IDX_FLAGS);
  wire wr_ist = wr_go && avs_address == tccc_addr(`TCCC_IDX_IRQ_STATUS);
  wire wr_imask = wr_go && avs_address == tccc_addr(`TCCC_IDX_IRQ_MASK);
  wire [NCH-1:0] flag_wd = avs_writedata[`TCCC_FLAG_CH0 +: NCH];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_q <= {NCH{1'b0}};
      ist_q <= {NCH{1'b0}};
      imask_q <= {NCH{1'b0}};
    end else begin
      // write 0 clears, set wins over clear
      flag_q <= ((wr_flags ? (flag_q & flag_wd) : flag_q)) | evt;
      // Status bit is write-one-to-clear; new event still wins
      ist_q <= ((wr_ist ? (ist_q & ~avs_writedata[NCH-1:0]) : ist_q)) | irq_evt;
      if (wr_imask) imask_q <= avs_writedata[NCH-1:0];
    end
  end

  assign irq = |(ist_q & imask_q);

  // Read mux; unmapped addresses read zero
  reg [7:0] rd_byte;
  integer i;
  always @* begin
    rd_byte = `TCCC_BYTE_ZERO;
    for (i = 0; i < NCH; i = i + 1) begin
      if (avs_address == tccc_addr(`TCCC_IDX_CH0_LOW + 2 * i)) rd_byte = val_q[i][7:0];
      if (avs_address == tccc_addr(`TCCC_IDX_CH0_HIGH + 2 * i)) rd_byte = val_q[i][15:8];
      if (avs_address == tccc_addr(`TCCC_IDX_CH0_CTL + i)) rd_byte = ctl_q[i];
    end
    if (avs_address == tccc_addr(`TCCC_IDX_FLAGS)) rd_byte = {flag_q, 5'b00000};
    if (avs_address == tccc_addr(`TCCC_IDX_IRQ_STATUS)) rd_byte = {5'b00000, ist_q};
    if (avs_address == tccc_addr(`TCCC_IDX_IRQ_MASK)) rd_byte = {5'b00000, imask_q};
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~rsp_q) begin
      avs_readdata <= {24'h00_0000, rd_byte};
    end
  end
endmodule

// [tccc_timer_model.sv]
`timescale 1ns/100ps
module tccc_timer_model (
  input wire clk,
  input wire rst,
  input wire run,
  input wire [1:0] mode,
  input wire [15:0] top,
  output logic [15:0] count_q,
  output logic down_q
);
  // Frozen count lets the bench know the exact captured value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= 16'h0000;
      down_q <= 1'b0;
    end else if (run) begin
      if (mode != 2'h3) begin
        down_q <= 1'b0;
        count_q <= (count_q >= top) ? 16'h0000 : count_q + 16'h0001;
      end else if (!down_q && count_q >= top) begin
        down_q <= 1'b1;
        count_q <= count_q - 16'h0001;
      end else if (down_q && count_q == 16'h0000) begin
        down_q <= 1'b0;
        count_q <= 16'h0001;
      end else begin
        count_q <= down_q ? count_q - 16'h0001 : count_q + 16'h0001;
      end
    end
  end
endmodule

// [tccc_channels_props.sv]
`timescale 1ns/100ps
module tccc_channels_props (
  input wire clk,
  input wire rst,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [15:0] timer_count,
  input wire [2:0] compare_out,
  input wire ch0_dma_trigger,
  input wire ch1_dma_trigger,
  input wire ch2_dma_trigger,
  input wire irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire [2:0] t = {ch2_dma_trigger, ch1_dma_trigger, ch0_dma_trigger};
  wire z = timer_count == 16'h0000;
  // Output may move with or one cycle after its own or channel 0's trigger, or after a zero count
  property p_wait;
    $rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("waitrequest timing wrong");
  property p_rdata;
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data upper bits set");
  property p_pulse0;
    t[0] |=> !t[0];
  endproperty
  a_pulse0: assert property (p_pulse0) else $error("trigger 0 too long");
  property p_pulse1;
    t[1] |=> !t[1];
  endproperty
  a_pulse1: assert property (p_pulse1) else $error("trigger 1 too long");
  property p_pulse2;
    t[2] |=> !t[2];
  endproperty
  a_pulse2: assert property (p_pulse2) else $error("trigger 2 too long");
  property p_out0;
    $changed(compare_out[0]) |-> t[0] || $past(t[0]) || $past(z) || $past(z, 2);
  endproperty
  a_out0: assert property (p_out0) else $error("output 0 moved without cause");
  property p_out1;
    $changed(compare_out[1]) |-> |t[1:0] || $past(|t[1:0]) || $past(z) || $past(z, 2);
  endproperty
  a_out1: assert property (p_out1) else $error("output 1 moved without cause");
  property p_out2;
    $changed(compare_out[2]) |-> t[2] || t[0] || $past(t[2] || t[0]) || $past(z) || $past(z, 2);
  endproperty
  a_out2: assert property (p_out2) else $error("output 2 moved without cause");
  c_trig: cover property (t[0]);
  c_irq: cover property ($rose(irq));
  c_out1: cover property ($rose(compare_out[1]));
endmodule
bind tccc_channels tccc_channels_props tccc_channels_props_i (.clk(clk), .rst(rst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .timer_count(timer_count), .compare_out(compare_out),
  .ch0_dma_trigger(ch0_dma_trigger), .ch1_dma_trigger(ch1_dma_trigger),
  .ch2_dma_trigger(ch2_dma_trigger), .irq(irq));

// [test_timer_capture_compare_channels.sv]
`timescale 1ns/100ps
`include "tccc_consts.vh"
module test_timer_capture_compare_channels;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] adr = 10'h000;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic run = 1'b1;
  logic [1:0] mode = 2'h2;
  logic [15:0] top = 16'h0010;
  logic [2:0] pin = 3'h0;
  wire [31:0] rdat;
  wire wait_req;
  wire [15:0] cnt;
  wire down;
  wire [2:0] cmp;
  wire [2:0] trg;
  wire irq;
  wire [3:0] ev = {irq, trg};
  int n_errors = 0;
  int tests_run = 0;
  logic [7:0] rd;
  logic dn;
  always #10 clk = ~clk;
  tccc_timer_model tccc_timer_model_i (.clk(clk), .rst(rst), .run(run), .mode(mode),
    .top(top), .count_q(cnt), .down_q(down));
  tccc_channels tccc_channels_i (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd_en),
    .avs_write(wr_en), .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wait_req),
    .timer_count(cnt), .count_down(down), .timer_mode(mode), .capture_pin(pin),
    .compare_out(cmp), .ch0_dma_trigger(trg[0]), .ch1_dma_trigger(trg[1]),
    .ch2_dma_trigger(trg[2]), .irq(irq));
  task automatic results;
    $display("mismatches %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n = 0;
    @(posedge clk);
    adr <= {idx, 2'b00};
    rd_en <= !wr;
    wr_en <= wr;
    wdat <= {24'h00_0000, wd};
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 20);
    rd = rdat[7:0];
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    if (wait_req !== 1'b0) begin
      chk(1'b1, 1'b0);
      results;
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask
  // Waits for one event bit, keeping the count direction seen with it
  task automatic wt(input int b);
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ev[b] !== 1'b1 && n < 300);
    dn = down;
    if (n >= 300) begin
      chk(1'b1, 1'b0);
      results;
    end else begin
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic t_reset;
    for (int i = 0; i < 3; i++) rdc(8'(`TCCC_IDX_CH0_CTL + i), `TCCC_CTL_RESET);
    for (int i = 0; i < 6; i++) rdc(8'(`TCCC_IDX_CH0_LOW + i), 8'h00);
    wr(8'hc0, 8'h5a);
    rdc(8'hc0, 8'h00);
  endtask
  task automatic t_rw;
    wr(`TCCC_IDX_CH1_CTL, 8'h3f);
    rdc(`TCCC_IDX_CH1_CTL, 8'h3f);
    wr(`TCCC_IDX_CH2_HIGH, 8'ha5);
    rdc(`TCCC_IDX_CH2_HIGH, 8'ha5);
    wr(`TCCC_IDX_CH2_HIGH, 8'h00);
  endtask
  task automatic t_codes;
    wr(`TCCC_IDX_CH0_LOW, 8'h10);
    // only codes 000 to 010 on channel 0
    for (int i = 0; i < 3; i++) begin
      wr(`TCCC_IDX_CH0_CTL, {2'b01, 3'(i), 3'b100});
      wt(0);
      chk(cmp[0], i != 1);
    end
  endtask
  task automatic t_updown;
    mode <= `TCCC_MODE_UPDOWN;
    wr(`TCCC_IDX_CH1_LOW, 8'h08);
    wr(`TCCC_IDX_CH2_LOW, 8'h08);
    wr(`TCCC_IDX_CH1_CTL, 8'h5c);
    wr(`TCCC_IDX_CH2_CTL, 8'h64);
    repeat (2) begin
      wt(1);
      chk(cmp[2:1], {dn, !dn});
    end
  endtask
  task automatic t_dual;
    mode <= 2'h2;
    wr(`TCCC_IDX_CH1_LOW, 8'h04);
    wr(`TCCC_IDX_CH1_CTL, 8'h6c);
    wr(`TCCC_IDX_CH2_CTL, 8'h74);
    wt(0);
    chk(cmp[2:1], 2'b10);
    wt(1);
    chk(cmp[1], 1'b1);
    wt(2);
    chk(cmp[2], 1'b0);
    // Outside up/down mode the zero count ends the pulse
    wr(`TCCC_IDX_CH1_CTL, 8'h5c);
    wr(`TCCC_IDX_CH2_CTL, 8'h64);
    wt(2);
    chk(cmp[2:1], 2'b01);
    wt(0);
    chk(cmp[2:1], 2'b10);
  endtask
  task automatic t_capture;
    for (int i = 0; i < 3; i++) wr(8'(`TCCC_IDX_CH0_CTL + i), 8'h40);
    run <= 1'b0;
    wr(`TCCC_IDX_IRQ_STATUS, 8'h07);
    wr(`TCCC_IDX_FLAGS, 8'h00);
    wr(`TCCC_IDX_IRQ_MASK, 8'h01);
    wr(`TCCC_IDX_CH0_CTL, 8'h42);
    pin <= 3'h1;
    repeat (6) @(posedge clk);
    chk(irq, 1'b0);
    pin <= 3'h0;
    wt(3);
    rdc(`TCCC_IDX_CH0_LOW, cnt[7:0]);
    rdc(`TCCC_IDX_CH0_HIGH, cnt[15:8]);
    wr(`TCCC_IDX_FLAGS, 8'he0);
    rdc(`TCCC_IDX_FLAGS, 8'h20);
    wr(`TCCC_IDX_FLAGS, 8'h00);
    rdc(`TCCC_IDX_FLAGS, 8'h00);
    wr(`TCCC_IDX_IRQ_STATUS, 8'h01);
    @(posedge clk);
    chk(irq, 1'b0);
    wr(`TCCC_IDX_CH0_CTL, 8'h03);
    pin <= 3'h1;
    repeat (6) @(posedge clk);
    rdc(`TCCC_IDX_FLAGS, 8'h20);
    chk(irq, 1'b0);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_rw;
    t_codes;
    t_updown;
    t_dual;
    t_capture;
    results;
  end
endmodule
